//--- ebg_pkg.sv
// shared constants, field layouts and carrier types of the external bus gateway
// assumes one processor clock domain; included by every gateway module
package ebg_pkg;

	// address windows that never leave the chip
	localparam logic [31:0] EBG_IMEM_BASE = 32'h0000_0000;
	localparam logic [31:0] EBG_IMEM_LAST = 32'h0000_FFFF;
	localparam logic [31:0] EBG_DMEM_BASE = 32'h8000_0000;
	localparam logic [31:0] EBG_DMEM_LAST = 32'h8000_1FFF;
	localparam logic [31:0] EBG_BROM_BASE = 32'hFFFF_0000;
	localparam logic [31:0] EBG_BROM_LAST = 32'hFFFF_7FFF;
	localparam logic [31:0] EBG_IO_BASE   = 32'hFFFF_FE00;
	localparam logic [31:0] EBG_IO_LAST   = 32'hFFFF_FFFF;
	localparam logic [31:0] EBG_XIP_BASE  = 32'hE000_0000;
	localparam logic [31:0] EBG_XIP_LAST  = 32'hEFFF_FFFF;

	// register byte offsets
	localparam logic [7:0] EBG_OFS_CTRL = 8'h00;
	localparam logic [7:0] EBG_OFS_TMO  = 8'h04;
	localparam logic [7:0] EBG_OFS_STAT = 8'h08;

	// control fields
	localparam int EBG_CTRL_PIPE   = 0;
	localparam int EBG_CTRL_BIG    = 1;
	localparam int EBG_CTRL_DIRECT = 2;
	// status fields
	localparam int EBG_STAT_BUSY = 0;
	localparam int EBG_STAT_HOLD = 1;
	localparam int EBG_STAT_TMO  = 2;
	localparam int EBG_STAT_ERR  = 3;

	// reset values
	localparam logic [2:0]  EBG_CTRL_RST = 3'h0;
	localparam logic [31:0] EBG_TMO_RST  = 32'h0000_00FF;

	// bus answers
	localparam logic [1:0] EBG_RESP_OK  = 2'h0;
	localparam logic [1:0] EBG_RESP_ERR = 2'h2;

	typedef enum logic [1:0] {
		EBG_IDLE = 2'b01,
		EBG_BUSY = 2'b10
	} ebg_state_t;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  ben;
		logic        we;
		logic        re;
		logic        priv;
		logic        ifetch;
		logic        lr;
		logic        fence;
		logic        fencei;
	} ebg_cpu_req_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        ack;
		logic        err;
	} ebg_cpu_rsp_t;

	typedef struct packed {
		logic [31:0] adr;
		logic [31:0] dat;
		logic [3:0]  sel;
		logic        we;
		logic        stb;
		logic        cyc;
		logic [2:0]  access_type_tag;
		logic        exclusive_hold;
	} ebg_wb_out_t;

	typedef struct packed {
		logic [31:0] dat;
		logic        ack;
		logic        err;
	} ebg_wb_in_t;

endpackage : ebg_pkg

//--- ebg_timeout.sv
// response watchdog of the external bus gateway
// assumes start is a one-cycle pulse and run is high while unanswered
`timescale 1ns/100ps
module ebg_timeout
	import ebg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// control
	input  wire logic        start_i,
	input  wire logic [31:0] limit_i,
	input  wire logic        run_i,
	// result
	output logic             expire_o
);

	logic [31:0] cnt_q;
	logic        en_q;

	// zero limit leaves the transfer waiting for ever
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= 32'h0000_0000;
			en_q  <= 1'b0;
		end else if (start_i) begin
			cnt_q <= limit_i;
			en_q  <= (limit_i != 32'h0000_0000);
		end else if (run_i && cnt_q != 32'h0000_0001) begin
			cnt_q <= cnt_q - 32'h0000_0001;
		end
	end

	assign expire_o = run_i && en_q && (cnt_q == 32'h0000_0001);

endmodule : ebg_timeout

//--- ebg_axil_regs.sv
// AXI4-Lite register slave of the external bus gateway
// assumes a single clock; one write and one read under way at a time
`timescale 1ns/100ps
module ebg_axil_regs
	import ebg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// write address and data
	input  wire logic [7:0]  s_axil_awaddr_i,
	input  wire logic        s_axil_awvalid_i,
	output logic             s_axil_awready_o,
	input  wire logic [31:0] s_axil_wdata_i,
	input  wire logic [3:0]  s_axil_wstrb_i,
	input  wire logic        s_axil_wvalid_i,
	output logic             s_axil_wready_o,
	output logic [1:0]       s_axil_bresp_o,
	output logic             s_axil_bvalid_o,
	input  wire logic        s_axil_bready_i,
	// read
	input  wire logic [7:0]  s_axil_araddr_i,
	input  wire logic        s_axil_arvalid_i,
	output logic             s_axil_arready_o,
	output logic [31:0]      s_axil_rdata_o,
	output logic [1:0]       s_axil_rresp_o,
	output logic             s_axil_rvalid_o,
	input  wire logic        s_axil_rready_i,
	// gateway side
	output logic [2:0]       ctrl_o,
	output logic [31:0]      tmo_o,
	input  wire logic        busy_i,
	input  wire logic        hold_i,
	input  wire logic        evt_tmo_i,
	input  wire logic        evt_err_i
);

	logic        aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic        tmo_flag_q, err_flag_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic        do_wr, clr_tmo, clr_err;

	assign s_axil_awready_o = !aw_full_q && !bvalid_q;
	assign s_axil_wready_o  = !w_full_q && !bvalid_q;
	assign s_axil_arready_o = !rvalid_q;
	assign s_axil_bvalid_o  = bvalid_q;
	assign s_axil_bresp_o   = bresp_q;
	assign s_axil_rvalid_o  = rvalid_q;
	assign s_axil_rdata_o   = rdata_q;
	assign s_axil_rresp_o   = rresp_q;

	assign do_wr   = aw_full_q && w_full_q && !bvalid_q;
	assign clr_tmo = do_wr && awaddr_q == EBG_OFS_STAT && wstrb_q[0]
		&& wdata_q[EBG_STAT_TMO];
	assign clr_err = do_wr && awaddr_q == EBG_OFS_STAT && wstrb_q[0]
		&& wdata_q[EBG_STAT_ERR];

	// address and data may arrive in either order
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else if (do_wr) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
		end else begin
			if (s_axil_awvalid_i && s_axil_awready_o) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axil_awaddr_i;
			end
			if (s_axil_wvalid_i && s_axil_wready_o) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axil_wdata_i;
				wstrb_q  <= s_axil_wstrb_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bvalid_q <= 1'b0;
			bresp_q  <= EBG_RESP_OK;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (awaddr_q == EBG_OFS_CTRL || awaddr_q == EBG_OFS_TMO
				|| awaddr_q == EBG_OFS_STAT) ? EBG_RESP_OK : EBG_RESP_ERR;
		end else if (s_axil_bready_i) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_o <= EBG_CTRL_RST;
			tmo_o  <= EBG_TMO_RST;
		end else if (do_wr) begin
			if (awaddr_q == EBG_OFS_CTRL && wstrb_q[0])
				ctrl_o <= wdata_q[2:0];
			if (awaddr_q == EBG_OFS_TMO) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_q[b])
						tmo_o[8*b +: 8] <= wdata_q[8*b +: 8];
				end
			end
		end
	end

	// sticky flags: a new event beats a clear in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tmo_flag_q <= 1'b0;
			err_flag_q <= 1'b0;
		end else begin
			tmo_flag_q <= evt_tmo_i || (tmo_flag_q && !clr_tmo);
			err_flag_q <= evt_err_i || (err_flag_q && !clr_err);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= EBG_RESP_OK;
		end else if (s_axil_arvalid_i && s_axil_arready_o) begin
			rvalid_q <= 1'b1;
			rresp_q  <= EBG_RESP_OK;
			rdata_q  <= 32'h0000_0000;
			case (s_axil_araddr_i)
				EBG_OFS_CTRL: rdata_q[2:0] <= ctrl_o;
				EBG_OFS_TMO:  rdata_q <= tmo_o;
				EBG_OFS_STAT: rdata_q[3:0] <= {err_flag_q, tmo_flag_q,
					hold_i, busy_i};
				default:      rresp_q <= EBG_RESP_ERR;
			endcase
		end else if (s_axil_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule : ebg_axil_regs

//--- ebg_gateway.sv
// external bus gateway: forwards CPU accesses that miss every internal
// window onto a classic or pipelined strobe bus, one transfer at a time
// assumes the CPU holds off a new access until the previous one is answered
//
// Function
// - gateway forwards nothing unless the external port is present
// - forward only accesses missing IMEM, DMEM, boot ROM and IO windows
// - accesses to the execute-in-place window are never forwarded
// - classic mode holds strobe and all controls until the transfer ends
// - pipelined mode raises strobe only in the first transfer cycle
// - no bursts, one transfer outstanding, no stall input
// - nonzero timeout drops cyc and reports an access fault on expiry
// - zero timeout waits for ever for ack or err
// - a nonzero timeout is the recommended setting
// - tag bit 0 high for machine-mode accesses
// - tag bit 1 always low, marking secure accesses
// - tag bit 2 high for instruction fetches
// - load-reserve raises exclusive hold until the next data access that is not a load-reserve; instruction fetches leave it
// - little byte order by default, big order reverses bytes
// - outgoing and returning signals registered by default
// - direct return bypasses the return register except for timeout faults
// - separate outputs flag fence and instruction-fence execution
`timescale 1ns/100ps
module ebg_gateway
	import ebg_pkg::*;
#(
	parameter bit EXT_PORT_PRESENT       = 1'b1,
	parameter bit IMEM_PRESENT           = 1'b1,
	parameter bit DMEM_PRESENT           = 1'b1,
	parameter bit EXECUTE_IN_PLACE_MODULE = 1'b0,
	parameter bit ATOMIC_SUPPORT_OPTION  = 1'b1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// CPU side
	input  wire ebg_cpu_req_t cpu_req_i,
	output ebg_cpu_rsp_t      cpu_rsp_o,
	output logic              fence_o,
	output logic              fencei_o,
	// external bus
	output ebg_wb_out_t       wb_o,
	input  wire ebg_wb_in_t   wb_i,
	// register bus
	input  wire logic [7:0]   s_axil_awaddr_i,
	input  wire logic         s_axil_awvalid_i,
	output logic              s_axil_awready_o,
	input  wire logic [31:0]  s_axil_wdata_i,
	input  wire logic [3:0]   s_axil_wstrb_i,
	input  wire logic         s_axil_wvalid_i,
	output logic              s_axil_wready_o,
	output logic [1:0]        s_axil_bresp_o,
	output logic              s_axil_bvalid_o,
	input  wire logic         s_axil_bready_i,
	input  wire logic [7:0]   s_axil_araddr_i,
	input  wire logic         s_axil_arvalid_i,
	output logic              s_axil_arready_o,
	output logic [31:0]       s_axil_rdata_o,
	output logic [1:0]        s_axil_rresp_o,
	output logic              s_axil_rvalid_o,
	input  wire logic         s_axil_rready_i
);

	ebg_state_t  state_q;
	ebg_wb_out_t wb_q;
	logic [2:0]  ctrl;
	logic [31:0] tmo_lim;
	logic [31:0] tx_dat, rx_dat, rdata_q;
	logic [3:0]  tx_sel;
	logic        pipelined_strobe_select, big_byte_order_select;
	logic        direct_return_select;
	logic        hit_int, hit_xip, access, fwd, start, answer, expire;
	logic        ack_q, err_q, fence_q, fencei_q;

	assign pipelined_strobe_select = ctrl[EBG_CTRL_PIPE];
	assign big_byte_order_select   = ctrl[EBG_CTRL_BIG];
	assign direct_return_select    = ctrl[EBG_CTRL_DIRECT];

	// address decode
	function automatic logic in_win(logic [31:0] a, logic [31:0] lo,
		logic [31:0] hi);
		in_win = (a >= lo) && (a <= hi);
	endfunction : in_win

	assign hit_int =
		(IMEM_PRESENT && in_win(cpu_req_i.addr, EBG_IMEM_BASE,
			EBG_IMEM_LAST)) ||
		(DMEM_PRESENT && in_win(cpu_req_i.addr, EBG_DMEM_BASE,
			EBG_DMEM_LAST)) ||
		in_win(cpu_req_i.addr, EBG_BROM_BASE, EBG_BROM_LAST) ||
		in_win(cpu_req_i.addr, EBG_IO_BASE, EBG_IO_LAST);
	assign hit_xip = EXECUTE_IN_PLACE_MODULE &&
		in_win(cpu_req_i.addr, EBG_XIP_BASE, EBG_XIP_LAST);
	assign access = cpu_req_i.re || cpu_req_i.we;
	assign fwd    = EXT_PORT_PRESENT && access && !hit_int && !hit_xip;
	assign start  = (state_q == EBG_IDLE) && fwd;
	assign answer = wb_q.cyc && (wb_i.ack || wb_i.err);

	// byte order: lanes mirrored when big order is selected
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_lane
			assign tx_dat[8*b +: 8] = big_byte_order_select ?
				cpu_req_i.wdata[8*(3-b) +: 8] : cpu_req_i.wdata[8*b +: 8];
			assign tx_sel[b] = big_byte_order_select ?
				cpu_req_i.ben[3-b] : cpu_req_i.ben[b];
			assign rx_dat[8*b +: 8] = big_byte_order_select ?
				wb_i.dat[8*(3-b) +: 8] : wb_i.dat[8*b +: 8];
		end
	endgenerate

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			state_q <= EBG_IDLE;
		else begin
			case (state_q)
				EBG_IDLE: if (start) state_q <= EBG_BUSY;
				EBG_BUSY: if (answer || expire) state_q <= EBG_IDLE;
				default:  state_q <= EBG_IDLE;
			endcase
		end
	end

	// outgoing register: controls latched at the start and held
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wb_q.adr <= 32'h0000_0000;
			wb_q.dat <= 32'h0000_0000;
			wb_q.sel <= 4'h0;
			wb_q.we  <= 1'b0;
			wb_q.stb <= 1'b0;
			wb_q.cyc <= 1'b0;
			wb_q.access_type_tag <= 3'h0;
			wb_q.exclusive_hold  <= 1'b0;
		end else begin
			if (start) begin
				wb_q.adr <= cpu_req_i.addr;
				wb_q.dat <= tx_dat;
				wb_q.sel <= tx_sel;
				wb_q.we  <= cpu_req_i.we;
				wb_q.stb <= 1'b1;
				wb_q.cyc <= 1'b1;
				wb_q.access_type_tag <= {cpu_req_i.ifetch, 1'b0,
					cpu_req_i.priv};
			end else if (answer || expire) begin
				wb_q.stb <= 1'b0;
				wb_q.cyc <= 1'b0;
			end else if (pipelined_strobe_select) begin
				wb_q.stb <= 1'b0;
			end
			// lock follows the last data access; any data access other than a load-reserve ends it
			if (ATOMIC_SUPPORT_OPTION && access && !cpu_req_i.ifetch)
				wb_q.exclusive_hold <= cpu_req_i.lr;
		end
	end

	assign wb_o = wb_q;

	ebg_timeout u_timeout (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.start_i (start),
		.limit_i (tmo_lim),
		.run_i   (wb_q.cyc && !wb_i.ack && !wb_i.err),
		.expire_o(expire)
	);

	// returning register; timeout faults always take this path
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= !direct_return_select && wb_q.cyc && wb_i.ack;
			err_q <= expire ||
				(!direct_return_select && wb_q.cyc && wb_i.err);
			if (wb_q.cyc && wb_i.ack)
				rdata_q <= rx_dat;
		end
	end

	always_comb begin
		if (direct_return_select) begin
			cpu_rsp_o.ack   = wb_q.cyc && wb_i.ack;
			cpu_rsp_o.err   = (wb_q.cyc && wb_i.err) || err_q;
			cpu_rsp_o.rdata = rx_dat;
		end else begin
			cpu_rsp_o.ack   = ack_q;
			cpu_rsp_o.err   = err_q;
			cpu_rsp_o.rdata = rdata_q;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fence_q  <= 1'b0;
			fencei_q <= 1'b0;
		end else begin
			fence_q  <= cpu_req_i.fence;
			fencei_q <= cpu_req_i.fencei;
		end
	end

	assign fence_o  = fence_q;
	assign fencei_o = fencei_q;

	ebg_axil_regs u_regs (
		.clk_i           (clk_i),
		.nrst_i          (nrst_i),
		.s_axil_awaddr_i (s_axil_awaddr_i),
		.s_axil_awvalid_i(s_axil_awvalid_i),
		.s_axil_awready_o(s_axil_awready_o),
		.s_axil_wdata_i  (s_axil_wdata_i),
		.s_axil_wstrb_i  (s_axil_wstrb_i),
		.s_axil_wvalid_i (s_axil_wvalid_i),
		.s_axil_wready_o (s_axil_wready_o),
		.s_axil_bresp_o  (s_axil_bresp_o),
		.s_axil_bvalid_o (s_axil_bvalid_o),
		.s_axil_bready_i (s_axil_bready_i),
		.s_axil_araddr_i (s_axil_araddr_i),
		.s_axil_arvalid_i(s_axil_arvalid_i),
		.s_axil_arready_o(s_axil_arready_o),
		.s_axil_rdata_o  (s_axil_rdata_o),
		.s_axil_rresp_o  (s_axil_rresp_o),
		.s_axil_rvalid_o (s_axil_rvalid_o),
		.s_axil_rready_i (s_axil_rready_i),
		.ctrl_o          (ctrl),
		.tmo_o           (tmo_lim),
		.busy_i          (wb_q.cyc),
		.hold_i          (wb_q.exclusive_hold),
		.evt_tmo_i       (expire),
		.evt_err_i       (answer && wb_i.err)
	);

	// checking logic: limit and age of the running transfer
	logic [31:0] lim_q, age_q;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lim_q <= 32'h0000_0000;
			age_q <= 32'h0000_0000;
		end else if (start) begin
			lim_q <= tmo_lim;
			age_q <= 32'h0000_0000;
		end else if (wb_q.cyc) begin
			age_q <= age_q + 32'h0000_0001;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_launch;
		start ##1 wb_q.cyc;
	endsequence

	sequence s_ack_seen;
		wb_q.cyc && wb_i.ack && !direct_return_select;
	endsequence

	a_internal_kept: assert property (
		(state_q == EBG_IDLE && access && (hit_int || hit_xip))
		|=> !wb_q.cyc)
		else $error("internal access reached the external bus");
	a_classic_stb: assert property (
		(wb_q.cyc && !pipelined_strobe_select) |-> wb_q.stb)
		else $error("classic strobe dropped during transfer");
	a_pipe_stb_once: assert property (
		(wb_q.cyc && $past(wb_q.cyc) && pipelined_strobe_select
		&& $past(pipelined_strobe_select)) |-> !wb_q.stb)
		else $error("pipelined strobe longer than one cycle");
	a_ctrl_stable: assert property (
		(wb_q.cyc && $past(wb_q.cyc)) |-> $stable(wb_q.adr)
		&& $stable(wb_q.we) && $stable(wb_q.sel))
		else $error("bus controls changed mid transfer");
	a_tmo_bound: assert property (
		(wb_q.cyc && lim_q != 32'h0000_0000) |-> age_q < lim_q)
		else $error("transfer outlived its timeout");
	a_tag_fields: assert property (
		s_launch |-> wb_q.access_type_tag ==
		{$past(cpu_req_i.ifetch), 1'b0, $past(cpu_req_i.priv)})
		else $error("access tag does not match the access");
	a_reg_return: assert property (
		s_ack_seen |=> cpu_rsp_o.ack && !wb_q.cyc)
		else $error("registered ack not passed on next cycle");
	a_direct_return: assert property (
		(wb_q.cyc && wb_i.ack && direct_return_select) |-> cpu_rsp_o.ack)
		else $error("direct ack not passed at once");
	a_err_fault: assert property (
		(wb_q.cyc && wb_i.err && !direct_return_select)
		|=> cpu_rsp_o.err && !cpu_rsp_o.ack)
		else $error("bus error not reported as a fault");
	a_lr_hold: assert property (
		(ATOMIC_SUPPORT_OPTION && access && !cpu_req_i.ifetch
		&& cpu_req_i.lr) |=> wb_q.exclusive_hold)
		else $error("load-reserve did not raise the hold");

endmodule : ebg_gateway

//--- ebg_wb_mem.sv
// far-side memory model of the gateway bus, sixteen words
// assumes one clock; answers ack or err delay_i+2 cycles after cyc rises, or never
`timescale 1ns/100ps
module ebg_wb_mem
	import ebg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// bus
	input  wire ebg_wb_out_t bus_i,
	output ebg_wb_in_t       bus_o,
	// behaviour
	input  wire logic [3:0]  delay_i,
	input  wire logic        err_i,
	input  wire logic        mute_i
);
	logic [31:0] mem_q [16];
	logic [3:0]  wait_q;
	logic        busy_q;
	logic        fire;

	// single master here, so nobody else reaches a reserved word
	assign fire = bus_i.cyc && busy_q && wait_q == 4'h0 && !mute_i;

	// ends each transfer by ack or err unless mute_i is high, err while err_i is high
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			bus_o  <= '0;
		end else begin
			bus_o.ack <= 1'b0;
			bus_o.err <= 1'b0;
			// released data lines flip every cycle, so the last word comes back every other cycle
			bus_o.dat <= ~bus_o.dat;
			if (!bus_i.cyc) begin
				busy_q <= 1'b0;
			end else if (!busy_q && !bus_o.ack && !bus_o.err) begin
				busy_q <= 1'b1;
				wait_q <= delay_i;
			end else if (busy_q && wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end else if (fire) begin
				busy_q    <= 1'b0;
				bus_o.ack <= !err_i;
				bus_o.err <= err_i;
				bus_o.dat <= mem_q[bus_i.adr[5:2]];
			end
		end
	end

	// stores land only when acknowledged
	always_ff @(posedge clk_i) begin
		for (int b = 0; b < 4; b++) begin
			if (fire && !err_i && bus_i.we && bus_i.sel[b]) begin
				mem_q[bus_i.adr[5:2]][8*b +: 8] <= bus_i.dat[8*b +: 8];
			end
		end
	end
endmodule : ebg_wb_mem

//--- ebg_gateway_bench.sv
// self-checking bench of the gateway against a word model of memory
// assumes the gateway and ebg_wb_mem share one 250 MHz clock
`timescale 1ns/100ps
module ebg_gateway_bench
	import ebg_pkg::*;
;
	logic         clk, nrst, fen, feni, serr, mute, lat_on;
	ebg_cpu_req_t req;
	ebg_cpu_rsp_t rsp;
	ebg_wb_out_t  wo;
	ebg_wb_in_t   wi;
	logic [3:0]   dly, wstrb;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata, tmo, r;
	logic         awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready;
	logic [1:0]   bresp, rresp;
	logic [2:0]   cfg;
	logic [31:0]  mdl [16];
	logic [31:0]  win [9] = '{32'h0000_FFFC, 32'h8000_0000, 32'hFFFF_7FFC,
		32'hFFFF_FE00, 32'h0001_0000, 32'h8000_2000, 32'hFFFF_8000,
		32'hFFFF_FDFC, 32'hE000_0000};
	int           bad_count = 0, checks_done = 0, cycles = 0, seed;

	ebg_gateway #(.EXECUTE_IN_PLACE_MODULE(1'b1)) dut (
		.clk_i(clk), .nrst_i(nrst), .cpu_req_i(req), .cpu_rsp_o(rsp),
		.fence_o(fen), .fencei_o(feni), .wb_o(wo), .wb_i(wi),
		.s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid),
		.s_axil_awready_o(awready), .s_axil_wdata_i(wdata),
		.s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid),
		.s_axil_wready_o(wready), .s_axil_bresp_o(bresp),
		.s_axil_bvalid_o(bvalid), .s_axil_bready_i(bready),
		.s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
		.s_axil_arready_o(arready), .s_axil_rdata_o(rdata),
		.s_axil_rresp_o(rresp), .s_axil_rvalid_o(rvalid),
		.s_axil_rready_i(rready));
	ebg_wb_mem far (.clk_i(clk), .nrst_i(nrst), .bus_i(wo), .bus_o(wi),
		.delay_i(dly), .err_i(serr), .mute_i(mute));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic stop_test;
		$display("mismatches %0d, checks %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, want %h", $time, s, e);
		end
	endtask : chk

	function automatic logic [31:0] swp(input logic [31:0] v);
		return cfg[1] ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
	endfunction : swp

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] e);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp, e);
		@(posedge clk);
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, e);
		chk(rresp, er);
		@(posedge clk);
	endtask : axr

	// m: 0 acked, 1 bus error, 2 kept on chip, 3 timed out
	task automatic acc(input logic [31:0] a, input logic w,
			input logic [31:0] d, input logic [3:0] be, input logic [2:0] t,
			input logic l, input int m);
		logic [3:0] ws;
		int         n;
		int         lat;
		ws = cfg[1] ? {be[0], be[1], be[2], be[3]} : be;
		req.addr   <= a;
		req.wdata  <= d;
		req.ben    <= be;
		req.we     <= w;
		req.re     <= !w;
		req.priv   <= t[0];
		req.ifetch <= t[2];
		req.lr     <= l;
		@(posedge clk);
		req.we <= 1'b0;
		req.re <= 1'b0;
		// timeout error comes in cycle T+1; the count starts in cycle 2
		lat = (m == 3) ? tmo - 1 : (m == 2) ? 4 : (cfg[2] ? 1 : 2) + dly;
		#1;
		chk(wo.cyc, m != 2);
		if (m != 2) begin
			chk(wo.adr, a);
			chk({wo.sel, wo.we, wo.stb}, {ws, w, 1'b1});
			chk(wo.access_type_tag, {t[2], 1'b0, t[0]});
			if (w) chk(wo.dat, swp(d));
		end
		@(posedge clk);
		#1;
		n = 0;
		while (rsp.ack !== 1'b1 && rsp.err !== 1'b1
				&& n < (m == 2 ? 4 : 300)) begin
			@(posedge clk);
			#1;
			n++;
			if (n == 1 && wo.cyc === 1'b1) chk(wo.stb, !cfg[0]);
		end
		if (lat_on) chk(n, lat);
		chk({rsp.ack, rsp.err}, m == 0 ? 2'h2 : m == 2 ? 2'h0 : 2'h1);
		if (m == 3) chk(wo.cyc, 1'b0);
		for (int b = 0; b < 4; b++) begin
			if (m == 0 && w && ws[b]) mdl[a[5:2]][8*b +: 8] = swp(d)[8*b +: 8];
		end
		if (m == 0 && !w) chk(rsp.rdata, swp(mdl[a[5:2]]));
		@(posedge clk);
	endtask : acc

	initial begin
		seed = 89;
		req = '0;
		{nrst, serr, mute, dly, cfg} = '0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		lat_on = 1'b1;
		tmo = 32'hFF;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		axr(EBG_OFS_CTRL, 32'h0, EBG_RESP_OK);
		axr(EBG_OFS_TMO, 32'hFF, EBG_RESP_OK);
		axr(EBG_OFS_STAT, 32'h0, EBG_RESP_OK);
		axr(8'h0C, 32'h0, EBG_RESP_ERR);
		axw(8'h0C, 32'h1, EBG_RESP_ERR);
		for (int i = 0; i < 16; i++) begin
			acc(32'h4000_0000 + 32'(4 * i), 1'b1, $random(seed), 4'hF, 3'h1, 1'b0, 0);
		end
		for (int i = 0; i < 9; i++) begin
			acc(win[i], 1'b0, 32'h0, 4'hF, 3'h1, 1'b0,
				(i < 4 || i == 8) ? 2 : 0);
		end
		for (int c = 0; c < 8; c++) begin
			cfg = 3'(c);
			axw(EBG_OFS_CTRL, 32'(c), EBG_RESP_OK);
			axr(EBG_OFS_CTRL, 32'(c), EBG_RESP_OK);
			repeat (6) begin
				r = $random(seed);
				dly <= {2'h0, r[17:16]};
				acc({26'h100_0000, r[15:12], 2'h0}, r[0], $random(seed),
					r[7:4] == 4'h0 ? 4'hF : r[7:4], {r[8] & !r[0], r[9], r[10]},
					1'b0, 0);
			end
		end
		acc(32'h4000_0008, 1'b0, 32'h0, 4'hF, 3'h1, 1'b1, 0);
		chk(wo.exclusive_hold, 1'b1);
		serr <= 1'b1;
		acc(32'h4000_0008, 1'b1, 32'h5A5A_A5A5, 4'hF, 3'h1, 1'b0, 1);
		serr <= 1'b0;
		chk(wo.exclusive_hold, 1'b0);
		axr(EBG_OFS_STAT, 32'h8, EBG_RESP_OK);
		axw(EBG_OFS_STAT, 32'h8, EBG_RESP_OK);
		tmo = 32'h4;
		axw(EBG_OFS_TMO, tmo, EBG_RESP_OK);
		mute <= 1'b1;
		acc(32'h4000_0010, 1'b0, 32'h0, 4'hF, 3'h1, 1'b0, 3);
		axr(EBG_OFS_STAT, 32'h4, EBG_RESP_OK);
		tmo = 32'h0;
		axw(EBG_OFS_TMO, tmo, EBG_RESP_OK);
		lat_on = 1'b0;
		fork
			acc(32'h4000_0010, 1'b0, 32'h0, 4'hF, 3'h1, 1'b0, 0);
			begin
				repeat (80) @(posedge clk);
				chk(wo.cyc, 1'b1);
				mute <= 1'b0;
			end
		join
		for (int i = 0; i < 2; i++) begin
			req.fence <= i == 0;
			req.fencei <= i == 1;
			@(posedge clk);
			{req.fence, req.fencei} <= 2'h0;
			#1;
			chk({fen, feni}, i ? 2'h1 : 2'h2);
			@(posedge clk);
			#1;
			chk({fen, feni}, 2'h0);
			@(posedge clk);
		end
		stop_test();
	end
endmodule : ebg_gateway_bench
